// File: logic/i2c_link_engine.sv
// Bit and byte engine running on the bus clock line itself.
// Assumes link_rst_n is asserted at every start and stop and released while the clock is low.
`timescale 1ns/1ns
`include "i2c_target_map.svh"

module i2c_link_engine #(
    parameter bit FOREIGN_OK = 1'b0
) (
    input  wire logic       scl,
    input  wire logic       link_rst_n,
    input  wire logic       sda_in,
    input  wire logic [6:0] own_addr,
    input  wire logic       gc_enable,
    input  wire logic [7:0] tx_byte,
    output logic            sda_oe,
    output logic [7:0]      rx_byte,
    output logic            addr_match,
    output logic            addr_read,
    output logic            addr_gc,
    output logic [3:0]      ev_tog
);

    logic [3:0]                 bit_cnt;
    logic [6:0]                 shift;
    logic [7:0]                 tx_shift;
    logic                       ack_flag;
    logic                       tx_tog;
    logic [2:0]                 pos_tog;
    i2c_target_pkg::link_phase_t phase;
    i2c_target_pkg::addr_kind_t  kind;
    logic                       accept;

    assign kind   = i2c_target_pkg::classify(shift, sda_in, own_addr);
    assign accept = (kind == i2c_target_pkg::KIND_OWN)
                 || (kind == i2c_target_pkg::KIND_GENCALL && gc_enable)
                 || (kind == i2c_target_pkg::KIND_FOREIGN && FOREIGN_OK);
    assign ev_tog = {pos_tog[2], tx_tog, pos_tog[1:0]};

    // Sampling on the rising edge, while data is valid
    always_ff @(posedge scl or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            bit_cnt    <= 4'h0;
            shift      <= 7'h00;
            phase      <= i2c_target_pkg::PH_ADDR;
            ack_flag   <= 1'b0;
            rx_byte    <= 8'h00;
            addr_match <= 1'b0;
            addr_read  <= 1'b0;
            addr_gc    <= 1'b0;
            pos_tog    <= 3'h0;
        end
        else
        begin
            bit_cnt <= (bit_cnt == `I2C_ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
            if (bit_cnt != `I2C_ACK_SLOT)
                shift <= {shift[5:0], sda_in};
            if (bit_cnt == `I2C_LAST_BIT)
            begin
                unique case (phase)
                    i2c_target_pkg::PH_ADDR:
                    begin
                        ack_flag   <= accept;
                        addr_match <= accept;
                        addr_read  <= accept && sda_in;
                        addr_gc    <= accept && (kind == i2c_target_pkg::KIND_GENCALL);
                        if (accept)
                            pos_tog[`I2C_EV_ADDR] <= ~pos_tog[`I2C_EV_ADDR];
                        if (!accept)
                            phase <= i2c_target_pkg::PH_IGNORE;
                        else if (sda_in)
                            phase <= i2c_target_pkg::PH_SEND;
                        else
                            phase <= i2c_target_pkg::PH_RECV;
                    end
                    i2c_target_pkg::PH_RECV:
                    begin
                        rx_byte  <= {shift, sda_in};
                        ack_flag <= 1'b1;
                        pos_tog[`I2C_EV_RX] <= ~pos_tog[`I2C_EV_RX];
                    end
                    i2c_target_pkg::PH_SEND,
                    i2c_target_pkg::PH_IGNORE:
                        ack_flag <= 1'b0;
                endcase
            end
            if (bit_cnt == `I2C_ACK_SLOT)
            begin
                ack_flag <= 1'b0;
                // Master's not-acknowledge ends our transmission
                if (phase == i2c_target_pkg::PH_SEND && !ack_flag && sda_in)
                begin
                    phase      <= i2c_target_pkg::PH_IGNORE;
                    pos_tog[2] <= ~pos_tog[2];
                end
            end
        end
    end

    // Driving on the falling edge, so data is settled before the clock rises
    always_ff @(negedge scl or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            sda_oe   <= 1'b0;
            tx_shift <= 8'h00;
            tx_tog   <= 1'b0;
        end
        else if (bit_cnt == `I2C_ACK_SLOT)
            sda_oe <= ack_flag;
        else if (bit_cnt == 4'h0 && phase == i2c_target_pkg::PH_SEND)
        begin
            tx_shift <= tx_byte;
            sda_oe   <= ~tx_byte[7];
            tx_tog   <= ~tx_tog;
        end
        else if (phase == i2c_target_pkg::PH_SEND)
            sda_oe <= ~tx_shift[3'(`I2C_LAST_BIT - bit_cnt)];
        else
            sda_oe <= 1'b0;
    end

endmodule : i2c_link_engine

// File: logic/i2c_target.sv
// Two-wire bus target: framing, addressing and clock-stretching flow control.
// Assumes an open-drain pad resolves the OE pins; SCL_IN also clocks the link engine.
`timescale 1ns/1ns
`include "i2c_target_map.svh"

module i2c_target #(
    parameter logic [3:0] FIXED_ADDR     = `I2C_FIXED_ADDR,
    parameter bit         FOREIGN_OK     = 1'b0,
    parameter int         BIT_STRETCH_NS = `I2C_BIT_STRETCH_NS
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    input  wire logic [2:0] ADDR_PIN,
    input  wire logic       GC_ENABLE,
    input  wire logic       HS_MODE,
    input  wire logic       BIT_STRETCH,
    input  wire logic       RX_READY,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    output logic            SCL_OUT,
    output logic            SCL_OE,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    output logic [7:0]      RX_DATA,
    output logic            RX_VALID,
    output logic            TX_READY,
    output logic            ADDRESSED,
    output logic            READ_MODE,
    output logic            GEN_CALL,
    output logic            BUS_BUSY
);

    localparam int         STRETCH_CYC_INT = (BIT_STRETCH_NS * `I2C_SYS_MHZ + 999) / 1000;
    localparam logic [7:0] STRETCH_CYC     = 8'((STRETCH_CYC_INT < 1) ? 1 : STRETCH_CYC_INT);

    // Input synchronisers
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    logic [2:0] pin_m;
    logic [2:0] pin_s;
    logic [3:0] tog_m;
    logic [3:0] tog_s;
    logic [3:0] tog_p;

    // Bus framing
    i2c_target_pkg::bus_state_t bus_state;
    i2c_target_pkg::bus_state_t next_bus_state;
    logic                       link_rst_n;
    logic                       start_seen;
    logic                       stop_seen;
    logic                       scl_fall;
    logic [3:0]                 ev;

    // Link engine outputs
    logic [7:0] link_rx_byte;
    logic       link_match;
    logic       link_read;
    logic       link_gc;
    logic [3:0] link_tog;

    // User side
    logic [7:0] tx_hold;
    logic       tx_full;
    logic       next_tx_full;
    logic       tx_active;
    logic       stall;
    logic [7:0] stretch_cnt;
    logic       next_scl_oe;

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
            pin_m <= 3'h0;
            pin_s <= 3'h0;
        end
        else
        begin
            scl_m <= SCL_IN;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= SDA_IN;
            sda_s <= sda_m;
            sda_p <= sda_s;
            pin_m <= ADDR_PIN;
            pin_s <= pin_m;
        end
    end

    // Event toggles from the link clock domain
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tog_m <= 4'h0;
            tog_s <= 4'h0;
            tog_p <= 4'h0;
        end
        else
        begin
            tog_m <= link_tog;
            tog_s <= tog_m;
            tog_p <= tog_s;
        end
    end

    // Toggles restart at zero under link reset, so edges outside a frame are discarded
    assign ev         = (tog_s ^ tog_p) & {4{bus_state == i2c_target_pkg::BUS_ACTIVE && link_rst_n}};
    assign start_seen = scl_s && scl_p && sda_p && !sda_s;
    assign stop_seen  = scl_s && scl_p && !sda_p && sda_s;
    assign scl_fall   = scl_p && !scl_s;

    always_comb
    begin
        next_bus_state = bus_state;
        unique case (bus_state)
            i2c_target_pkg::BUS_IDLE:
                if (start_seen)
                    next_bus_state = i2c_target_pkg::BUS_START;
            i2c_target_pkg::BUS_START:
                // A stop here is an empty message; treat it as a plain stop
                if (stop_seen)
                    next_bus_state = i2c_target_pkg::BUS_IDLE;
                else if (!scl_s)
                    next_bus_state = i2c_target_pkg::BUS_ACTIVE;
            i2c_target_pkg::BUS_ACTIVE:
                if (start_seen)
                    next_bus_state = i2c_target_pkg::BUS_START;
                else if (stop_seen)
                    next_bus_state = i2c_target_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bus_state <= i2c_target_pkg::BUS_IDLE;
            BUS_BUSY  <= 1'b0;
        end
        else
        begin
            bus_state <= next_bus_state;
            BUS_BUSY  <= (next_bus_state != i2c_target_pkg::BUS_IDLE);
        end
    end

    // Link reset is released only while the clock line is low, so no edge races the release
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            link_rst_n <= 1'b0;
        else
            link_rst_n <= (bus_state == i2c_target_pkg::BUS_ACTIVE) && !start_seen && !stop_seen;
    end

    // Addressed state follows the address event and is dropped at every start and stop
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ADDRESSED <= 1'b0;
            READ_MODE <= 1'b0;
            GEN_CALL  <= 1'b0;
            tx_active <= 1'b0;
        end
        else if (bus_state != i2c_target_pkg::BUS_ACTIVE || start_seen || stop_seen)
        begin
            ADDRESSED <= 1'b0;
            READ_MODE <= 1'b0;
            GEN_CALL  <= 1'b0;
            tx_active <= 1'b0;
        end
        else if (ev[`I2C_EV_ADDR])
        begin
            ADDRESSED <= link_match;
            READ_MODE <= link_read;
            GEN_CALL  <= link_gc;
            tx_active <= link_read;
        end
        else if (ev[`I2C_EV_NACK])
            tx_active <= 1'b0;
    end

    // Received bytes; a new byte wins over a same-cycle consume
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RX_VALID <= 1'b0;
            RX_DATA  <= 8'h00;
        end
        else if (ev[`I2C_EV_RX])
        begin
            RX_VALID <= 1'b1;
            RX_DATA  <= link_rx_byte;
        end
        else if (RX_READY)
            RX_VALID <= 1'b0;
    end

    // Transmit byte; a stale byte is dropped at start and stop so it never opens a later read
    always_comb
    begin
        next_tx_full = tx_full;
        if (TX_VALID && !tx_full)
            next_tx_full = 1'b1;
        else if (ev[`I2C_EV_TX] || start_seen || stop_seen)
            next_tx_full = 1'b0;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_full  <= 1'b0;
            tx_hold  <= 8'h00;
            TX_READY <= 1'b1;
        end
        else
        begin
            tx_full  <= next_tx_full;
            TX_READY <= !next_tx_full;
            if (TX_VALID && !tx_full)
                tx_hold <= TX_DATA;
        end
    end

    // Byte-level wait: unread receive byte or missing transmit byte
    assign stall = (ADDRESSED && !READ_MODE && RX_VALID)
                || (tx_active && !tx_full);

    // Bit-level wait, suppressed in high-speed mode
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
            stretch_cnt <= 8'h00;
        else if (bus_state != i2c_target_pkg::BUS_ACTIVE)
            stretch_cnt <= 8'h00;
        else if (scl_fall && ADDRESSED && BIT_STRETCH && !HS_MODE)
            stretch_cnt <= STRETCH_CYC;
        else if (stretch_cnt != 8'h00)
            stretch_cnt <= stretch_cnt - 8'h01;
    end

    // Only grab a line already seen low, never pull a high clock down mid-phase
    assign next_scl_oe = (bus_state == i2c_target_pkg::BUS_ACTIVE)
                      && !start_seen && !stop_seen
                      && (!scl_s || SCL_OE)
                      && (stall || stretch_cnt != 8'h00 || scl_fall && ADDRESSED && BIT_STRETCH && !HS_MODE);

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SCL_OE  <= 1'b0;
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end
        else
        begin
            SCL_OE  <= next_scl_oe;
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
        end
    end

    // tx_hold and the address are steady whenever the link clock can sample them
    i2c_link_engine #(
        .FOREIGN_OK (FOREIGN_OK)
    ) u_link (
        .scl        (SCL_IN),
        .link_rst_n (link_rst_n),
        .sda_in     (SDA_IN),
        .own_addr   ({FIXED_ADDR, pin_s}),
        .gc_enable  (GC_ENABLE),
        .tx_byte    (tx_hold),
        .sda_oe     (SDA_OE),
        .rx_byte    (link_rx_byte),
        .addr_match (link_match),
        .addr_read  (link_read),
        .addr_gc    (link_gc),
        .ev_tog     (link_tog)
    );

endmodule : i2c_target

// File: logic/i2c_target_map.svh
// Constants for the two-wire bus target: address patterns, bit slots, timing.
// Assumes inclusion by bare name from the package and the design modules.
// Summary of operation
// - After a byte and its acknowledge, a busy target holds the clock low; for address and receive bytes the code holds it in the low before the ack clock.
// - A slow target may lengthen every clock low phase; the master adapts.
// - In high-speed mode only byte-level stretching is used, never bit-level.
// - First byte after a start is a 7-bit address plus direction bit.
// - On a read the target acks the address, then transmits; master nacks last byte.
// - Direction change repeats start and address with inverted direction bit.
// - Every byte, address or data, is followed by one acknowledge slot.
// - Any start, even misplaced, resets the bus logic to expect an address.
// - All-zero address with write is a general call, acknowledged only if wanted.
// - Target compares the seven address bits; a match selects receive or transmit.
// - Own address is fixed upper bits plus pin-selected lower bits.
// - All-zero address with read is a wake-up pattern; never acknowledged.
// - Address 0000001 in either direction is never answered.
// - Address 0000010 is answered only by targets built for that foreign format.
// - Groups 0000XXX and 1111XXX are reserved and never ordinary addresses.
// - Pattern 11110XX marks 10-bit addressing and never matches as 7-bit.
// - A stretching target resumes by releasing the clock once ready.
// - An acknowledging receiver holds data low through the acknowledge high phase.
// - A target not accepting its address leaves data released in the ack slot.
// - Stop is data rising with clock high; start is data falling with clock high.
`ifndef I2C_TARGET_MAP_SVH
`define I2C_TARGET_MAP_SVH

`define I2C_GC_ADDR        7'h00
`define I2C_TRI_WIRE_ADDR  7'h01
`define I2C_FOREIGN_ADDR   7'h02
`define I2C_LOW_GROUP      4'h0
`define I2C_HIGH_GROUP     4'hF
`define I2C_TEN_BIT_PREFIX 5'h1E
`define I2C_FIXED_ADDR     4'hA

`define I2C_LAST_BIT       4'h7
`define I2C_ACK_SLOT       4'h8

`define I2C_EV_ADDR        0
`define I2C_EV_RX          1
`define I2C_EV_TX          2
`define I2C_EV_NACK        3
`define I2C_EV_W           4

`define I2C_SYS_MHZ        250
`define I2C_BIT_STRETCH_NS 200

`endif

// File: logic/i2c_target_pkg.sv
// Types and address classification for the two-wire bus target.
// Assumes the constant header is reachable by bare name.
`include "i2c_target_map.svh"

package i2c_target_pkg;

    typedef enum logic [2:0] {
        KIND_OWN,
        KIND_GENCALL,
        KIND_WAKE,
        KIND_TRI_WIRE,
        KIND_FOREIGN,
        KIND_TEN_BIT,
        KIND_RESERVED,
        KIND_OTHER
    } addr_kind_t;

    typedef enum logic [1:0] {
        PH_ADDR,
        PH_RECV,
        PH_SEND,
        PH_IGNORE
    } link_phase_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_START,
        BUS_ACTIVE
    } bus_state_t;

    // Reserved patterns are checked before the own address, so a reserved own address never matches
    function automatic addr_kind_t classify(input logic [6:0] addr, input logic rw, input logic [6:0] own);
        if (addr == `I2C_GC_ADDR)
            return rw ? KIND_WAKE : KIND_GENCALL;
        if (addr == `I2C_TRI_WIRE_ADDR)
            return KIND_TRI_WIRE;
        if (addr == `I2C_FOREIGN_ADDR)
            return KIND_FOREIGN;
        if (addr[6:2] == `I2C_TEN_BIT_PREFIX)
            return KIND_TEN_BIT;
        if (addr[6:3] == `I2C_LOW_GROUP || addr[6:3] == `I2C_HIGH_GROUP)
            return KIND_RESERVED;
        if (addr == own)
            return KIND_OWN;
        return KIND_OTHER;
    endfunction : classify

endpackage : i2c_target_pkg

// File: tb/i2c_address_decode_and_stretch_test.sv
// Self-checking bench for the two-wire bus target with a behavioural master.
// Assumes own address is the fixed part 4'hA over the pin bits.
`timescale 1ns/1ns
module i2c_address_decode_and_stretch_test;
    typedef struct {
        logic [2:0] pins;
        logic [7:0] first;
        logic       gc;
        logic       ack;
    } row_t;
    row_t rows [15] = '{
        '{3'h5, 8'hAA, 1'b0, 1'b1}, '{3'h5, 8'hA8, 1'b0, 1'b0}, '{3'h2, 8'hA4, 1'b0, 1'b1},
        '{3'h2, 8'hAA, 1'b0, 1'b0}, '{3'h5, 8'h00, 1'b1, 1'b1}, '{3'h5, 8'h00, 1'b0, 1'b0},
        '{3'h5, 8'h01, 1'b1, 1'b0}, '{3'h5, 8'h02, 1'b1, 1'b0}, '{3'h5, 8'h03, 1'b1, 1'b0},
        '{3'h5, 8'h04, 1'b1, 1'b0}, '{3'h5, 8'h05, 1'b1, 1'b0}, '{3'h5, 8'h06, 1'b1, 1'b0},
        '{3'h5, 8'h1A, 1'b1, 1'b0}, '{3'h5, 8'hFC, 1'b1, 1'b0}, '{3'h5, 8'hF3, 1'b1, 1'b0}};
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic [2:0] addr_pin = 3'h5;
    logic       gc_enable = 1'b0;
    logic       hs_mode = 1'b0;
    logic       bit_stretch = 1'b0;
    logic       rx_ready = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       tx_valid = 1'b0;
    logic       scl_oe, sda_oe, rx_valid, tx_ready, addressed, read_mode, gen_call, bus_busy;
    logic       m_scl_low, m_sda_low, nack, prev_rx_valid;
    logic [7:0] rx_data, got;
    wire        scl = !(m_scl_low || scl_oe);
    wire        sda = !(m_sda_low || sda_oe);
    int         miscompares = 0;
    int         samples_checked = 0;
    int         stretch_cycles = 0;

    always #2 clk_sys = !clk_sys;

    i2c_target #(.BIT_STRETCH_NS(20)) u_i2c_target (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .ADDR_PIN(addr_pin),
        .GC_ENABLE(gc_enable), .HS_MODE(hs_mode), .BIT_STRETCH(bit_stretch), .RX_READY(rx_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_OUT(), .SDA_OE(sda_oe),
        .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_READY(tx_ready), .ADDRESSED(addressed),
        .READ_MODE(read_mode), .GEN_CALL(gen_call), .BUS_BUSY(bus_busy));

    i2c_master_model u_i2c_master_model (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));

    // Clock held low outside a byte wait counts as bit level stretching
    always @(posedge clk_sys)
    begin
        prev_rx_valid <= rx_valid;
        if (scl_oe && !rx_valid && !prev_rx_valid && !read_mode) stretch_cycles++;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    task automatic rx_take(input logic [7:0] exp);
        int n = 0;
        while (rx_valid !== 1'b1 && n < 500) @(negedge clk_sys) n++;
        check("rx data", rx_data, exp);
        repeat (12) @(negedge clk_sys);
        check("byte wait", 8'(scl_oe), 8'h01);
        rx_ready = 1'b1;
        @(negedge clk_sys);
        rx_ready = 1'b0;
    endtask : rx_take

    initial
    begin
        #100000;
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        check("reset", {2'b00, scl_oe, sda_oe, rx_valid, tx_ready, addressed, bus_busy}, 8'h04);
        foreach (rows[i])
        begin
            addr_pin = rows[i].pins;
            gc_enable = rows[i].gc;
            repeat (4) @(negedge clk_sys);
            u_i2c_master_model.start_cond();
            check("busy", 8'(bus_busy), 8'h01);
            u_i2c_master_model.write_byte(rows[i].first, nack);
            check("ack", 8'(!nack), 8'(rows[i].ack));
            check("gen call", 8'(gen_call), 8'(rows[i].first == 8'h00 && rows[i].ack));
            if (rows[i].first != 8'h00) check("addressed", 8'(addressed), 8'(rows[i].ack));
            check("read mode", 8'(read_mode), 8'h00);
            u_i2c_master_model.stop_cond();
            check("cleared", {5'h00, bus_busy, addressed, gen_call}, 8'h00);
        end
        addr_pin = 3'h5;
        for (int k = 0; k < 3; k++)
        begin
            bit_stretch = (k != 0);
            hs_mode = (k == 2);
            stretch_cycles = 0;
            u_i2c_master_model.start_cond();
            u_i2c_master_model.write_byte(8'hAA, nack);
            fork
                u_i2c_master_model.write_byte(8'h81, nack);
                rx_take(8'h81);
            join
            check("data ack", 8'(nack), 8'h00);
            u_i2c_master_model.stop_cond();
            check("bit stretch", 8'(stretch_cycles != 0), 8'(k == 1));
        end
        bit_stretch = 1'b0;
        hs_mode = 1'b0;
        u_i2c_master_model.start_cond();
        fork
            u_i2c_master_model.write_byte(8'hAB, nack);
            begin
                int n = 0;
                while (read_mode !== 1'b1 && n < 500) @(negedge clk_sys) n++;
                repeat (12) @(negedge clk_sys);
                check("tx wait", 8'(scl_oe), 8'h01);
                tx_data = 8'h96;
                tx_valid = 1'b1;
            end
        join
        check("read ack", {6'h00, nack, read_mode}, 8'h01);
        u_i2c_master_model.read_byte(1'b1, got);
        check("read data", got, 8'h96);
        @(negedge clk_sys);
        tx_valid = 1'b0;
        u_i2c_master_model.start_cond();
        u_i2c_master_model.write_byte(8'hAA, nack);
        check("turnaround", {6'h00, nack, read_mode}, 8'h00);
        u_i2c_master_model.start_cond();
        u_i2c_master_model.clock_bit(1'b1, got[0]);
        u_i2c_master_model.clock_bit(1'b0, got[0]);
        u_i2c_master_model.clock_bit(1'b1, got[0]);
        u_i2c_master_model.start_cond();
        u_i2c_master_model.write_byte(8'hAA, nack);
        check("restart ack", 8'(nack), 8'h00);
        u_i2c_master_model.stop_cond();
        report_and_stop();
    end
endmodule : i2c_address_decode_and_stretch_test

// File: tb/i2c_master_model.sv
// Behavioural bus master: drives clock and data low or releases them.
// Assumes the bench resolves both lines with pull-ups; clock idles high.
`timescale 1ns/1ns
module i2c_master_model #(
    parameter int T_LOW  = 16,
    parameter int T_HIGH = 10
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // A slow target may hold the clock; bounded so a stuck line cannot hang
    task automatic release_clock;
        int n = 0;
        scl_low = 1'b0;
        while (scl !== 1'b1 && n < 2000) #1 n++;
    endtask : release_clock

    // Data moves 4 ns after the fall so it never looks like a start or stop
    task automatic clock_bit(input logic b, output logic seen);
        #4 sda_low = !b;
        #T_LOW release_clock();
        #(T_HIGH / 2) seen = sda;
        #(T_HIGH - T_HIGH / 2) scl_low = 1'b1;
    endtask : clock_bit

    task automatic write_byte(input logic [7:0] data, output logic nack);
        for (int i = 7; i >= 0; i--) clock_bit(data[i], nack);
        clock_bit(1'b1, nack);
    endtask : write_byte

    task automatic read_byte(input logic nack_last, output logic [7:0] data);
        logic seen;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, data[i]);
        clock_bit(nack_last, seen);
    endtask : read_byte

    task automatic start_cond;
        #4 sda_low = 1'b0;
        #10 release_clock();
        #10 sda_low = 1'b1;
        #12 scl_low = 1'b1;
        #10;
    endtask : start_cond

    task automatic stop_cond;
        #4 sda_low = 1'b1;
        #10 release_clock();
        #10 sda_low = 1'b0;
        #30;
    endtask : stop_cond
endmodule : i2c_master_model

// File: tb/i2c_target_chk.sv
// Assertion checker for the two-wire bus target, bound to its top module.
// Assumes SCL_IN and SDA_IN carry the resolved open-drain bus levels.
`timescale 1ns/1ns
module i2c_target_chk (
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       SCL_IN,
    input wire logic       SDA_IN,
    input wire logic       HS_MODE,
    input wire logic       BIT_STRETCH,
    input wire logic       RX_READY,
    input wire logic       TX_VALID,
    input wire logic       SCL_OUT,
    input wire logic       SCL_OE,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    input wire logic [7:0] RX_DATA,
    input wire logic       RX_VALID,
    input wire logic       TX_READY,
    input wire logic       ADDRESSED,
    input wire logic       READ_MODE,
    input wire logic       GEN_CALL,
    input wire logic       BUS_BUSY
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    AST_PINS_ONLY_PULL_LOW: assert property (!SCL_OUT && !SDA_OUT && (BUS_BUSY || !SCL_OE))
        else $error("bus pin driven high or clock held while idle");
    AST_STOP_CLEARS: assert property ($past(SCL_IN) && SCL_IN && $rose(SDA_IN) |-> ##[1:8]
        (!BUS_BUSY && !ADDRESSED && !READ_MODE && !GEN_CALL))
        else $error("stop did not clear the target state");
    AST_START_BUSY: assert property ($past(SCL_IN) && SCL_IN && $fell(SDA_IN) |-> ##[1:8]
        (BUS_BUSY && !ADDRESSED))
        else $error("start not seen or addressed state kept");
    AST_IDLE_RELEASED: assert property (!BUS_BUSY && !$past(BUS_BUSY) |-> !SDA_OE && !SCL_OE)
        else $error("bus line held while idle");
    AST_STALL_ENDS: assert property (SCL_OE && RX_VALID && RX_READY && !BIT_STRETCH |-> ##[1:3] !SCL_OE)
        else $error("clock not released after byte consumed");
    AST_RX_HELD: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA))
        else $error("received byte lost before consumed");
    AST_RX_TAKEN: assert property (RX_VALID && RX_READY |=> !RX_VALID)
        else $error("received byte not cleared when consumed");
    AST_TX_TAKEN: assert property (TX_VALID && TX_READY |=> !TX_READY)
        else $error("offered byte not taken");
    AST_HS_BYTE_ONLY: assert property (HS_MODE && SCL_OE |-> RX_VALID || $past(RX_VALID) || READ_MODE)
        else $error("bit level stretch in high speed mode");
    AST_ACK_STEADY: assert property ($past(SCL_IN) && SCL_IN |-> $stable(SDA_OE))
        else $error("data drive changed while clock high");
endmodule : i2c_target_chk

bind i2c_target i2c_target_chk u_i2c_target_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .HS_MODE(HS_MODE),
    .BIT_STRETCH(BIT_STRETCH), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .SCL_OUT(SCL_OUT),
    .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .TX_READY(TX_READY), .ADDRESSED(ADDRESSED), .READ_MODE(READ_MODE), .GEN_CALL(GEN_CALL),
    .BUS_BUSY(BUS_BUSY));
